//--- rtl/rscs_pkg.sv
// Package of constants and types for the remote status command interpreter
// What this block does
// RL1 - Reset command restores all default settings
// RL2 - Local/remote selector: 0, 1, 2, queryable
// RL3 - Remote override bit, writable and queryable
// RL4 - Software trigger equals hardware trigger event
// RL5 - One-argument event enable loads whole mask
// RL6 - Two-argument event enable sets one bit
// RL7 - Event enable query: whole byte or bit
// RL8 - Event status query: whole byte or bit
// RL9 - One-argument service enable loads whole mask
// RL10 - Two-argument service enable sets one bit
// RL11 - Service enable query: whole byte or bit
// RL12 - Clear-status clears all status bytes
// RL13 - Poll bit 5 set on enabled event
// RL14 - Event bit 5 illegal, bit 4 failure
// RL15 - Answers are decimal text with terminator
package rscs_pkg;
    typedef enum logic [3:0] {
        RSCS_OP_RESET,
        RSCS_OP_LOCAL_REMOTE,
        RSCS_OP_OVERRIDE,
        RSCS_OP_TRIGGER,
        RSCS_OP_CLEAR,
        RSCS_OP_EVT_ENABLE,
        RSCS_OP_EVT_STATUS,
        RSCS_OP_SRQ_ENABLE,
        RSCS_OP_POLL_STATUS
    } rscs_op_t;

    localparam logic [1:0] RSCS_LR_LOCAL    = 2'h0;
    localparam logic [1:0] RSCS_LR_REMOTE   = 2'h1;
    localparam logic [1:0] RSCS_LR_LOCKOUT  = 2'h2;
    localparam logic [1:0] RSCS_LR_RESET    = 2'h0;
    localparam logic       RSCS_OVR_RESET   = 1'h0;
    localparam logic [7:0] RSCS_EVT_EN_RESET = 8'h00;
    localparam logic [7:0] RSCS_SRQ_EN_RESET = 8'h00;
    localparam int         RSCS_EVT_EXE_BIT = 4;
    localparam int         RSCS_EVT_CMD_BIT = 5;
    localparam int         RSCS_POLL_ESB_BIT = 5;
    localparam logic [7:0] RSCS_CHAR_ZERO   = 8'h30;
    localparam logic [7:0] RSCS_CHAR_LF     = 8'h0A;
    localparam logic [7:0] RSCS_MAX_BYTE    = 8'hFF;
endpackage : rscs_pkg

//--- rtl/rscs_sync.sv
// Two-stage synchroniser for the trigger pin
`timescale 1ns/1ps
module rscs_sync
    import rscs_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = ce ? din : meta_q;
        sync_d = ce ? meta_q : sync_q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule : rscs_sync

//--- rtl/rscs_text.sv
// Serialises a byte value as decimal ASCII digits and a line feed
`timescale 1ns/1ps
module rscs_text
    import rscs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic [7:0] value,
    output logic            busy,
    output logic [7:0]      tx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready
);
    logic [7:0] dig_q [3];
    logic [7:0] dig_d [3];
    logic [1:0] idx_q;
    logic [1:0] idx_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic       busy_q;
    logic       busy_d;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic       vld_q;
    logic       vld_d;
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] u;

    always_comb begin
        h      = value / 8'd100;
        t      = (value / 8'd10) % 8'd10;
        u      = value % 8'd10;
        dig_d  = dig_q;
        idx_d  = idx_q;
        cnt_d  = cnt_q;
        busy_d = busy_q;
        data_d = data_q;
        vld_d  = vld_q;
        if (!busy_q && start) begin
            // Leading zeros suppressed, a zero still yields one digit
            busy_d = 1'b1;
            idx_d  = 2'd0;
            if (h != 8'd0) begin
                dig_d[0] = RSCS_CHAR_ZERO + h;
                dig_d[1] = RSCS_CHAR_ZERO + t;
                dig_d[2] = RSCS_CHAR_ZERO + u;
                cnt_d    = 2'd3;
            end else if (t != 8'd0) begin
                dig_d[0] = RSCS_CHAR_ZERO + t;
                dig_d[1] = RSCS_CHAR_ZERO + u;
                cnt_d    = 2'd2;
            end else begin
                dig_d[0] = RSCS_CHAR_ZERO + u;
                cnt_d    = 2'd1;
            end
            data_d = dig_d[0];
            vld_d  = 1'b1;
        end else if (busy_q && vld_q && tx_ready) begin
            if (data_q == RSCS_CHAR_LF) begin
                vld_d  = 1'b0;
                busy_d = 1'b0;
            end else if (idx_q + 2'd1 == cnt_q) begin
                data_d = RSCS_CHAR_LF; // RL15
            end else begin
                idx_d  = idx_q + 2'd1;
                data_d = dig_q[idx_q + 2'd1]; // RL15
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dig_q  <= '{8'h00, 8'h00, 8'h00};
            idx_q  <= 2'h0;
            cnt_q  <= 2'h0;
            busy_q <= 1'b0;
            data_q <= 8'h00;
            vld_q  <= 1'b0;
        end else if (ce) begin
            dig_q  <= dig_d;
            idx_q  <= idx_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            data_q <= data_d;
            vld_q  <= vld_d;
        end
    end

    assign busy     = busy_q;
    assign tx_data  = data_q;
    assign tx_valid = vld_q;
endmodule : rscs_text

//--- rtl/rscs_top.sv
// Command interpreter for local/remote, trigger and status commands
`timescale 1ns/1ps
module rscs_top
    import rscs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic       cmd_valid,
    input  wire rscs_op_t   cmd_op,
    input  wire logic       cmd_query,
    input  wire logic [1:0] cmd_nargs,
    input  wire logic [8:0] cmd_arg_i,
    input  wire logic [8:0] cmd_arg_j,
    output logic            cmd_ready,
    input  wire logic       cmd_illegal,
    input  wire logic       soft_launch_cmd_pin,
    output logic            launch,
    output logic [1:0]      local_remote_select,
    output logic            remote_override_select,
    output logic [7:0]      evt_enable,
    output logic [7:0]      evt_status,
    output logic [7:0]      srq_enable,
    output logic [7:0]      poll_status,
    output logic [7:0]      tx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready
);
    logic [1:0] lr_q;
    logic [1:0] lr_d;
    logic       ovr_q;
    logic       ovr_d;
    logic [7:0] ee_q;
    logic [7:0] ee_d;
    logic [7:0] es_q;
    logic [7:0] es_d;
    logic [7:0] se_q;
    logic [7:0] se_d;
    logic [7:0] ps_q;
    logic [7:0] ps_d;
    logic       launch_q;
    logic       launch_d;
    logic       soft_launch_cmd_s;
    logic       soft_launch_cmd_prev_q;
    logic       soft_launch_cmd_prev_d;
    logic       rdy_q;
    logic       rdy_d;
    logic       start_d;
    logic       start_q;
    logic [7:0] val_d;
    logic [7:0] val_q;
    logic       txt_busy;
    logic       accept;
    logic       bit_ok;
    logic       one_ok;
    logic [2:0] bi;

    rscs_sync u_sync (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .din    (soft_launch_cmd_pin),
        .dout   (soft_launch_cmd_s)
    );

    rscs_text u_text (
        .clk      (clk),
        .resetn   (resetn),
        .ce       (ce),
        .start    (start_q),
        .value    (val_q),
        .busy     (txt_busy),
        .tx_data  (tx_data),
        .tx_valid (tx_valid),
        .tx_ready (tx_ready)
    );

    always_comb begin
        // Commands held off while an answer is still being sent
        accept      = cmd_valid && rdy_q;
        bi          = cmd_arg_i[2:0];
        bit_ok      = (cmd_arg_i < 9'd8) && (cmd_arg_j < 9'd2);
        one_ok      = cmd_arg_i <= {1'b0, RSCS_MAX_BYTE};
        lr_d        = lr_q;
        ovr_d       = ovr_q;
        ee_d        = ee_q;
        es_d        = es_q;
        se_d        = se_q;
        soft_launch_cmd_prev_d = soft_launch_cmd_s;
        launch_d    = soft_launch_cmd_s && !soft_launch_cmd_prev_q; // RL4
        start_d     = 1'b0;
        val_d       = val_q;
        if (accept) begin
            case (cmd_op)
                RSCS_OP_RESET: begin
                    lr_d  = RSCS_LR_RESET; // RL1
                    ovr_d = RSCS_OVR_RESET; // RL1
                    ee_d  = RSCS_EVT_EN_RESET; // RL1
                    se_d  = RSCS_SRQ_EN_RESET; // RL1
                end
                RSCS_OP_LOCAL_REMOTE: begin
                    if (cmd_query) begin
                        start_d = 1'b1;
                        val_d   = {6'h00, lr_q}; // RL2
                    end else if (cmd_arg_i <= {7'h00, RSCS_LR_LOCKOUT}) begin
                        lr_d = cmd_arg_i[1:0]; // RL2
                    end else begin
                        es_d[RSCS_EVT_EXE_BIT] = 1'b1; // RL14
                    end
                end
                RSCS_OP_OVERRIDE: begin
                    if (cmd_query) begin
                        start_d = 1'b1;
                        val_d   = {7'h00, ovr_q}; // RL3
                    end else if (cmd_arg_i < 9'd2) begin
                        ovr_d = cmd_arg_i[0]; // RL3
                    end else begin
                        es_d[RSCS_EVT_EXE_BIT] = 1'b1; // RL14
                    end
                end
                RSCS_OP_TRIGGER: begin
                    launch_d = 1'b1; // RL4
                end
                RSCS_OP_CLEAR: begin
                    es_d = 8'h00; // RL12
                end
                RSCS_OP_EVT_ENABLE: begin
                    if (cmd_query) begin
                        start_d = 1'b1;
                        if (cmd_nargs == 2'd0) begin
                            val_d = ee_q; // RL7
                        end else if (cmd_arg_i < 9'd8) begin
                            val_d = {7'h00, ee_q[bi]}; // RL7
                        end else begin
                            start_d = 1'b0;
                            es_d[RSCS_EVT_EXE_BIT] = 1'b1; // RL14
                        end
                    end else if (cmd_nargs == 2'd1 && one_ok) begin
                        ee_d = cmd_arg_i[7:0]; // RL5
                    end else if (cmd_nargs == 2'd2 && bit_ok) begin
                        ee_d[bi] = cmd_arg_j[0]; // RL6
                    end else begin
                        es_d[RSCS_EVT_EXE_BIT] = 1'b1; // RL14
                    end
                end
                RSCS_OP_EVT_STATUS: begin
                    start_d = 1'b1;
                    if (cmd_nargs == 2'd0) begin
                        val_d = es_q; // RL8
                    end else if (cmd_arg_i < 9'd8) begin
                        val_d = {7'h00, es_q[bi]}; // RL8
                    end else begin
                        start_d = 1'b0;
                        es_d[RSCS_EVT_EXE_BIT] = 1'b1; // RL14
                    end
                end
                RSCS_OP_SRQ_ENABLE: begin
                    if (cmd_query) begin
                        start_d = 1'b1;
                        if (cmd_nargs == 2'd0) begin
                            val_d = se_q; // RL11
                        end else if (cmd_arg_i < 9'd8) begin
                            val_d = {7'h00, se_q[bi]}; // RL11
                        end else begin
                            start_d = 1'b0;
                            es_d[RSCS_EVT_EXE_BIT] = 1'b1; // RL14
                        end
                    end else if (cmd_nargs == 2'd1 && one_ok) begin
                        se_d = cmd_arg_i[7:0]; // RL9
                    end else if (cmd_nargs == 2'd2 && bit_ok) begin
                        se_d[bi] = cmd_arg_j[0]; // RL10
                    end else begin
                        es_d[RSCS_EVT_EXE_BIT] = 1'b1; // RL14
                    end
                end
                RSCS_OP_POLL_STATUS: begin
                    start_d = 1'b1;
                    if (cmd_nargs == 2'd0) begin
                        val_d = ps_q; // RL13
                    end else if (cmd_arg_i < 9'd8) begin
                        val_d = {7'h00, ps_q[bi]}; // RL13
                    end else begin
                        start_d = 1'b0;
                        es_d[RSCS_EVT_EXE_BIT] = 1'b1; // RL14
                    end
                end
                default: begin
                    es_d[RSCS_EVT_CMD_BIT] = 1'b1; // RL14
                end
            endcase
            // A flagged parse error still sets its bit, even beside a clear
            if (cmd_illegal) begin
                es_d[RSCS_EVT_CMD_BIT] = 1'b1; // RL14
            end
        end
        ps_d = 8'h00;
        ps_d[RSCS_POLL_ESB_BIT] = |(es_d & ee_d); // RL13
        rdy_d = !(start_d || start_q || txt_busy);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lr_q        <= RSCS_LR_RESET;
            ovr_q       <= RSCS_OVR_RESET;
            ee_q        <= RSCS_EVT_EN_RESET;
            es_q        <= 8'h00;
            se_q        <= RSCS_SRQ_EN_RESET;
            ps_q        <= 8'h00;
            launch_q    <= 1'b0;
            soft_launch_cmd_prev_q <= 1'b0;
            rdy_q       <= 1'b0;
            start_q     <= 1'b0;
            val_q       <= 8'h00;
        end else if (ce) begin
            lr_q        <= lr_d;
            ovr_q       <= ovr_d;
            ee_q        <= ee_d;
            es_q        <= es_d;
            se_q        <= se_d;
            ps_q        <= ps_d;
            launch_q    <= launch_d;
            soft_launch_cmd_prev_q <= soft_launch_cmd_prev_d;
            rdy_q       <= rdy_d;
            start_q     <= start_d;
            val_q       <= val_d;
        end
    end

    assign cmd_ready              = rdy_q;
    assign launch                 = launch_q;
    assign local_remote_select    = lr_q;
    assign remote_override_select = ovr_q;
    assign evt_enable             = ee_q;
    assign evt_status             = es_q;
    assign srq_enable             = se_q;
    assign poll_status            = ps_q;
endmodule : rscs_top

//--- test/rscs_host.sv
// Host model: accepts answer bytes and rebuilds the decimal value
`timescale 1ns/1ps
module rscs_host (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    output logic [15:0]      ans_q,
    output logic [7:0]       n_ans_q
);
    logic [15:0] acc_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_ready <= 1'b0;
            acc_q    <= 16'h0000;
            ans_q    <= 16'h0000;
            n_ans_q  <= 8'h00;
        end else begin
            // Slow host only accepts every other cycle
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                if (tx_data == 8'h0A) begin
                    ans_q   <= acc_q;
                    n_ans_q <= n_ans_q + 8'h01;
                    acc_q   <= 16'h0000;
                end else begin
                    acc_q <= acc_q * 16'h000A + {8'h00, tx_data - 8'h30};
                end
            end
        end
    end
endmodule : rscs_host

//--- test/rscs_properties.sv
// Port assertions for the command interpreter
`timescale 1ns/1ps
module rscs_properties
    import rscs_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       ce,
    input wire logic       cmd_valid,
    input wire rscs_op_t   cmd_op,
    input wire logic       cmd_query,
    input wire logic [1:0] cmd_nargs,
    input wire logic [8:0] cmd_arg_i,
    input wire logic [8:0] cmd_arg_j,
    input wire logic       cmd_ready,
    input wire logic       cmd_illegal,
    input wire logic       launch,
    input wire logic [1:0] local_remote_select,
    input wire logic       remote_override_select,
    input wire logic [7:0] evt_enable,
    input wire logic [7:0] evt_status,
    input wire logic [7:0] srq_enable,
    input wire logic [7:0] poll_status,
    input wire logic       tx_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic       take;
    logic       set1;
    logic       bit2;
    logic [7:0] bmask;
    logic [7:0] evt_exp;
    logic [7:0] srq_exp;
    assign take    = ce & cmd_valid & cmd_ready;
    assign set1    = take & !cmd_query & (cmd_nargs == 2'h1);
    assign bit2    = take & !cmd_query & (cmd_nargs == 2'h2) & (cmd_arg_i < 9'h008)
                     & (cmd_arg_j < 9'h002);
    assign bmask   = 8'h01 << cmd_arg_i[2:0];
    assign evt_exp = cmd_arg_j[0] ? (evt_enable | bmask) : (evt_enable & ~bmask);
    assign srq_exp = cmd_arg_j[0] ? (srq_enable | bmask) : (srq_enable & ~bmask);

    reset_defaults_a: assert property (take && !cmd_query && cmd_op == RSCS_OP_RESET |=>
        local_remote_select == RSCS_LR_RESET && remote_override_select == RSCS_OVR_RESET
        && evt_enable == RSCS_EVT_EN_RESET && srq_enable == RSCS_SRQ_EN_RESET) else $error("reset defaults");
    lr_load_a: assert property (set1 && cmd_op == RSCS_OP_LOCAL_REMOTE && cmd_arg_i < 9'h003
        |=> {7'h00, local_remote_select} == $past(cmd_arg_i)) else $error("selector load");
    soft_launch_cmd_launch_a: assert property (take && !cmd_query && cmd_op == RSCS_OP_TRIGGER
        |=> launch) else $error("no launch");
    evt_load_a: assert property (set1 && cmd_op == RSCS_OP_EVT_ENABLE && !cmd_arg_i[8]
        |=> {1'b0, evt_enable} == $past(cmd_arg_i)) else $error("event mask load");
    evt_bit_a: assert property (bit2 && cmd_op == RSCS_OP_EVT_ENABLE
        |=> evt_enable == $past(evt_exp)) else $error("event mask bit");
    srq_load_a: assert property (set1 && cmd_op == RSCS_OP_SRQ_ENABLE && !cmd_arg_i[8]
        |=> {1'b0, srq_enable} == $past(cmd_arg_i)) else $error("poll mask load");
    srq_bit_a: assert property (bit2 && cmd_op == RSCS_OP_SRQ_ENABLE
        |=> srq_enable == $past(srq_exp)) else $error("poll mask bit");
    clear_all_a: assert property (take && cmd_op == RSCS_OP_CLEAR && !cmd_illegal
        |=> evt_status == 8'h00) else $error("status not cleared");
    poll_sum_a: assert property (poll_status[5] == |(evt_status & evt_enable))
        else $error("summary bit");
    illegal_flag_a: assert property (take && cmd_illegal |=> evt_status[5])
        else $error("illegal not flagged");
    range_err_a: assert property (set1 && cmd_op == RSCS_OP_EVT_ENABLE && cmd_arg_i[8]
        |=> evt_status[4] && $stable(evt_enable)) else $error("range error");
    answer_start_a: assert property (take && (cmd_nargs == 2'h0 || cmd_arg_i < 9'h008)
        && (cmd_op == RSCS_OP_EVT_STATUS || cmd_op == RSCS_OP_POLL_STATUS || (cmd_query
        && (cmd_op == RSCS_OP_LOCAL_REMOTE || cmd_op == RSCS_OP_OVERRIDE
        || cmd_op == RSCS_OP_EVT_ENABLE || cmd_op == RSCS_OP_SRQ_ENABLE)))
        |-> ##2 tx_valid)
        else $error("answer late");
    query_cov: cover property (take && cmd_query);
    launch_cov: cover property (launch);
    illegal_cov: cover property (take && cmd_illegal);
endmodule : rscs_properties

bind rscs_top rscs_properties chk (.clk, .resetn, .ce, .cmd_valid, .cmd_op, .cmd_query,
    .cmd_nargs, .cmd_arg_i, .cmd_arg_j, .cmd_ready, .cmd_illegal, .launch,
    .local_remote_select, .remote_override_select, .evt_enable, .evt_status, .srq_enable,
    .poll_status, .tx_valid);

//--- test/rscs_top_tb.sv
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
module rscs_top_tb
    import rscs_pkg::*;
;
    logic        clk, resetn, cmd_valid, cmd_query, cmd_illegal, soft_launch_cmd_pin, slow, ce;
    rscs_op_t    cmd_op;
    logic [1:0]  cmd_nargs, local_remote_select;
    logic [8:0]  cmd_arg_i, cmd_arg_j;
    logic        cmd_ready, launch, remote_override_select, tx_valid, tx_ready;
    logic [7:0]  evt_enable, evt_status, srq_enable, poll_status, tx_data, n_ans;
    logic [15:0] ans;
    int          err_count = 0, n_tests = 0, cycles = 0, n_launch = 0;

    rscs_top uut (.clk(clk), .resetn(resetn), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_query(cmd_query), .cmd_nargs(cmd_nargs), .cmd_arg_i(cmd_arg_i),
        .cmd_arg_j(cmd_arg_j), .cmd_ready(cmd_ready), .cmd_illegal(cmd_illegal),
        .soft_launch_cmd_pin(soft_launch_cmd_pin), .launch(launch), .local_remote_select(local_remote_select),
        .remote_override_select(remote_override_select), .evt_enable(evt_enable),
        .evt_status(evt_status), .srq_enable(srq_enable), .poll_status(poll_status),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    rscs_host host (.clk(clk), .resetn(resetn), .slow(slow), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .ans_q(ans), .n_ans_q(n_ans));

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Holds the command until a ready edge takes it
    task automatic send(input rscs_op_t op, input logic q, input logic [1:0] n,
                        input logic [8:0] i, input logic [8:0] j, input logic ill);
        int k;
        @(posedge clk);
        #1;
        {cmd_valid, cmd_op, cmd_query, cmd_nargs} = {1'b1, op, q, n};
        {cmd_arg_i, cmd_arg_j, cmd_illegal} = {i, j, ill};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 60);
        #1;
        cmd_valid = 1'b0;
        check(16'(k < 60), 16'h0001);
    endtask : send

    task automatic ask(input rscs_op_t op, input logic [1:0] n, input logic [8:0] i,
                       input logic [15:0] exp);
        logic [7:0] m;
        int         k;
        m = n_ans;
        send(op, 1'b1, n, i, 9'h000, 1'b0);
        for (k = 0; k < 100 && n_ans === m; k++) @(posedge clk);
        check(ans, exp);
    endtask : ask

    task automatic t_lr;
        for (int v = 0; v < 3; v++) begin
            send(RSCS_OP_LOCAL_REMOTE, 1'b0, 2'h1, 9'(v), 9'h000, 1'b0);
            check({14'h0000, local_remote_select}, 16'(v));
            ask(RSCS_OP_LOCAL_REMOTE, 2'h0, 9'h000, 16'(v));
        end
        send(RSCS_OP_OVERRIDE, 1'b0, 2'h1, 9'h001, 9'h000, 1'b0);
        check({15'h0000, remote_override_select}, 16'h0001);
        ask(RSCS_OP_OVERRIDE, 2'h0, 9'h000, 16'h0001);
    endtask : t_lr

    task automatic t_masks;
        send(RSCS_OP_EVT_ENABLE, 1'b0, 2'h1, 9'h025, 9'h000, 1'b0);
        check({8'h00, evt_enable}, 16'h0025);
        slow = 1'b1;
        ask(RSCS_OP_EVT_ENABLE, 2'h0, 9'h000, 16'h0025);
        slow = 1'b0;
        send(RSCS_OP_EVT_ENABLE, 1'b0, 2'h2, 9'h007, 9'h001, 1'b0);
        check({8'h00, evt_enable}, 16'h00A5);
        ask(RSCS_OP_EVT_ENABLE, 2'h1, 9'h000, 16'h0001);
        send(RSCS_OP_EVT_ENABLE, 1'b0, 2'h1, 9'h12C, 9'h000, 1'b0);
        check({8'h00, evt_enable}, 16'h00A5);
        check({15'h0000, evt_status[4]}, 16'h0001);
        send(RSCS_OP_SRQ_ENABLE, 1'b0, 2'h1, 9'h0FF, 9'h000, 1'b0);
        ask(RSCS_OP_SRQ_ENABLE, 2'h0, 9'h000, 16'h00FF);
        send(RSCS_OP_SRQ_ENABLE, 1'b0, 2'h2, 9'h000, 9'h000, 1'b0);
        check({8'h00, srq_enable}, 16'h00FE);
        ask(RSCS_OP_SRQ_ENABLE, 2'h1, 9'h000, 16'h0000);
    endtask : t_masks

    task automatic t_status;
        send(RSCS_OP_CLEAR, 1'b0, 2'h0, 9'h000, 9'h000, 1'b0);
        check({8'h00, evt_status}, 16'h0000);
        send(rscs_op_t'(4'hF), 1'b0, 2'h0, 9'h000, 9'h000, 1'b1);
        check({15'h0000, evt_status[5]}, 16'h0001);
        @(posedge clk);
        check({15'h0000, poll_status[5]}, 16'h0001);
        ask(RSCS_OP_EVT_STATUS, 2'h1, 9'h005, 16'h0001);
        ask(RSCS_OP_POLL_STATUS, 2'h0, 9'h000, 16'h0020);
        send(RSCS_OP_CLEAR, 1'b0, 2'h0, 9'h000, 9'h000, 1'b0);
        @(posedge clk);
        check({8'h00, evt_status, poll_status}, 16'h0000);
    endtask : t_status

    task automatic t_soft_launch_cmd;
        int n0;
        n0 = n_launch;
        @(posedge clk);
        #1;
        soft_launch_cmd_pin = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        soft_launch_cmd_pin = 1'b0;
        send(RSCS_OP_TRIGGER, 1'b0, 2'h0, 9'h000, 9'h000, 1'b0);
        repeat (3) @(posedge clk);
        check(16'(n_launch - n0), 16'h0002);
    endtask : t_soft_launch_cmd

    task automatic t_rst;
        send(RSCS_OP_RESET, 1'b0, 2'h0, 9'h000, 9'h000, 1'b0);
        check({local_remote_select, remote_override_select, evt_enable, srq_enable}, 16'h0000);
    endtask : t_rst

    // Frozen clock enable must swallow a standing command
    task automatic t_ce;
        @(posedge clk);
        #1;
        ce = 1'b0;
        {cmd_valid, cmd_op, cmd_query, cmd_nargs} = {1'b1, RSCS_OP_LOCAL_REMOTE, 1'b0, 2'h1};
        {cmd_arg_i, cmd_arg_j, cmd_illegal} = {9'h001, 9'h000, 1'b0};
        repeat (3) @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        ce = 1'b1;
        check({14'h0000, local_remote_select}, 16'h0000);
    endtask : t_ce

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (launch === 1'b1) n_launch++;
        cycles++;
        // Whole run needs a few thousand cycles at most
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        {resetn, cmd_valid, cmd_query, cmd_illegal, soft_launch_cmd_pin, slow} = 6'h00;
        ce = 1'b1;
        {cmd_op, cmd_nargs, cmd_arg_i, cmd_arg_j} = {RSCS_OP_RESET, 2'h0, 9'h000, 9'h000};
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_lr();
        t_masks();
        t_status();
        t_soft_launch_cmd();
        t_rst();
        t_ce();
        wrap_up();
    end
endmodule : rscs_top_tb
